/* common/rox_pkg.sv */
// Constants and types for the return and option instruction executor
// Notes on behaviour
// - Interrupt return pops stack into program counter
// - Interrupt return sets global interrupt enable bit
// - Interrupt return opcode fixed, two cycles, no flags
// - Literal return loads working register with literal
// - Literal return pops stack into program counter
// - Literal return pattern ignores two bits, two cycles
// - Subroutine return pops stack, interrupt enable untouched
// - Subroutine return opcode fixed, two cycles, no flags
package rox_pkg;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned INT_ENABLE_BIT = 7;
  localparam logic [13:0] OP_RET_INT = 14'h0009;
  localparam logic [13:0] OP_RET_SUB = 14'h0008;
  localparam logic [13:0] OP_OPTION = 14'h0062;
  localparam logic [13:0] RET_LIT_MASK = 14'h3c00;
  localparam logic [13:0] RET_LIT_VAL = 14'h3400;
  localparam logic [12:0] ADDR_RST = 13'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;

  typedef enum logic [1:0] {
    ROX_IDLE,
    ROX_SECOND
  } rox_state_t;

  // Result of one executed instruction
  typedef struct packed {
    logic program_counter_load;
    logic [12:0] program_counter_value;
    logic stack_pop;
    logic w_load;
    logic [7:0] w_value;
    logic global_interrupt_enable_set;
    logic option_load;
    logic [7:0] option_value;
  } rox_out_t;

  // Whole module state
  typedef struct packed {
    rox_state_t state;
    logic busy;
    rox_out_t out;
  } rox_reg_t;
endpackage : rox_pkg

/* src/rox_exec.sv */
// Executor for interrupt return, literal return, subroutine return, option
`timescale 1ns/100ps
`default_nettype none
module rox_exec (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic [12:0] top_of_stack_i,
  input wire logic [7:0] working_reg_i,
  output logic instr_ready_o,
  output logic busy_o,
  output rox_pkg::rox_out_t out_o
);
  // ----------------------------------------
  // Local signals
  // ----------------------------------------
  logic is_rfi;
  logic is_rsub;
  logic is_rlw;
  logic is_opt;
  logic is_ret;
  logic take;
  logic take_ret;
  logic take_lit;
  logic take_opt;
  logic [rox_pkg::ADDR_W-1:0] addr_cap;
  logic [rox_pkg::DATA_W-1:0] lit_cap;
  logic [rox_pkg::DATA_W-1:0] opt_cap;
  rox_pkg::rox_reg_t st_r;
  rox_pkg::rox_reg_t st_nxt;

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  // Interrupt return
  assign is_rfi = (instr_i == rox_pkg::OP_RET_INT);

  // Subroutine return
  assign is_rsub = (instr_i == rox_pkg::OP_RET_SUB);

  // Literal return, two middle bits ignored
  assign is_rlw = ((instr_i & rox_pkg::RET_LIT_MASK) ==
                   rox_pkg::RET_LIT_VAL);

  // Legacy option load
  assign is_opt = (instr_i == rox_pkg::OP_OPTION);

  // Any two-cycle return
  assign is_ret = is_rfi || is_rsub || is_rlw;

  // ----------------------------------------
  // Handshake
  // ----------------------------------------
  // Ready outside the stall cycle of a return
  assign instr_ready_o = !st_r.busy;

  // Instruction accepted on this edge
  assign take = ce_i && instr_valid_i && !st_r.busy;

  // Accepted return of any kind
  assign take_ret = take && is_ret;

  // Accepted literal return
  assign take_lit = take && is_rlw;

  // Accepted option load
  assign take_opt = take && !is_ret && is_opt;

  // ----------------------------------------
  // Operand capture
  // ----------------------------------------
  // Return address, held until the next return
  for (genvar b = 0; b < rox_pkg::ADDR_W; b++) begin : g_addr
    assign addr_cap[b] = take_ret ? top_of_stack_i[b] :
                         st_r.out.program_counter_value[b];
  end

  // Literal, held until the next literal return
  for (genvar b = 0; b < rox_pkg::DATA_W; b++) begin : g_lit
    assign lit_cap[b] = take_lit ? instr_i[b] :
                        st_r.out.w_value[b];
  end

  // Working register copy, held until the next option load
  for (genvar b = 0; b < rox_pkg::DATA_W; b++) begin : g_opt
    assign opt_cap[b] = take_opt ? working_reg_i[b] :
                        st_r.out.option_value[b];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Strobes last one enabled cycle
    st_nxt.out.program_counter_load = 1'b0;
    st_nxt.out.stack_pop = 1'b0;
    st_nxt.out.w_load = 1'b0;
    st_nxt.out.global_interrupt_enable_set = 1'b0;
    st_nxt.out.option_load = 1'b0;
    // Values hold until reloaded
    st_nxt.out.program_counter_value = addr_cap;
    st_nxt.out.w_value = lit_cap;
    st_nxt.out.option_value = opt_cap;
    unique case (st_r.state)
      rox_pkg::ROX_IDLE: begin
        st_nxt.busy = 1'b0;
        if (take_ret) begin
          st_nxt.out.stack_pop = 1'b1;
          st_nxt.out.program_counter_load = 1'b1;
          st_nxt.out.global_interrupt_enable_set = is_rfi;
          st_nxt.state = rox_pkg::ROX_SECOND;
          st_nxt.busy = 1'b1;
          if (is_rlw) begin
            st_nxt.out.w_load = 1'b1;
          end
        end else if (take_opt) begin
          st_nxt.out.option_load = 1'b1;
        end
      end
      rox_pkg::ROX_SECOND: begin
        // Stall cycle of a two-cycle return
        st_nxt.state = rox_pkg::ROX_IDLE;
        st_nxt.busy = 1'b0;
      end
      default: begin
        st_nxt.state = rox_pkg::ROX_IDLE;
        st_nxt.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always_comb begin
    out_o = st_r.out;
    busy_o = st_r.busy;
  end
endmodule : rox_exec
`default_nettype wire

/* tb/rox_exec_checker.sv */
// Port assertions for the return and option executor
`timescale 1ns/100ps
`default_nettype none
module rox_exec_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic instr_valid_i,
  input wire logic [13:0] instr_i,
  input wire logic [12:0] top_of_stack_i,
  input wire logic [7:0] working_reg_i,
  input wire logic instr_ready_o,
  input wire logic busy_o,
  input wire rox_pkg::rox_out_t out_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire tk = ce_i && instr_valid_i && instr_ready_o;
  wire lit = tk && instr_i[13:10] == 4'hd;
  wire ret = lit || tk && instr_i[13:1] == 13'h0004;
  property p_addr;
    ret |=> out_o.program_counter_value == $past(top_of_stack_i);
  endproperty
  a_addr: assert property (p_addr)
    else $error("return address not loaded");
  property p_pop;
    out_o.stack_pop && $past(ce_i) |->
      out_o.program_counter_load && $past(ret);
  endproperty
  a_pop: assert property (p_pop)
    else $error("stack pop without return");
  property p_int;
    tk && instr_i == 14'h0009 |=> out_o.global_interrupt_enable_set;
  endproperty
  a_int: assert property (p_int)
    else $error("interrupt enable not set");
  property p_sub;
    tk && instr_i == 14'h0008 |=>
      !out_o.global_interrupt_enable_set && out_o.stack_pop;
  endproperty
  a_sub: assert property (p_sub)
    else $error("subroutine return wrong");
  property p_lit;
    lit |=> out_o.w_load && out_o.w_value == $past(instr_i[7:0]);
  endproperty
  a_lit: assert property (p_lit)
    else $error("literal not loaded");
  property p_two;
    ret |=> busy_o ##1 !busy_o;
  endproperty
  a_two: assert property (p_two)
    else $error("return not two cycles");
  property p_rdy;
    busy_o && $past(ce_i) |-> !instr_ready_o && $past(ret);
  endproperty
  a_rdy: assert property (p_rdy)
    else $error("stall without return");
  property p_opt;
    tk && instr_i == 14'h0062 |=>
      out_o.option_load && out_o.option_value == $past(working_reg_i);
  endproperty
  a_opt: assert property (p_opt)
    else $error("option not loaded");
endmodule : rox_exec_checker
bind rox_exec rox_exec_checker rox_exec_checker_i (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .ce_i(ce_i),
  .instr_valid_i(instr_valid_i),
  .instr_i(instr_i),
  .top_of_stack_i(top_of_stack_i),
  .working_reg_i(working_reg_i),
  .instr_ready_o(instr_ready_o),
  .busy_o(busy_o),
  .out_o(out_o)
);
`default_nettype wire

/* tb/rox_exec_tb.sv */
// Random bench for the return and option executor
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module rox_exec_tb;
  logic clk_i = 1'b0, reset_n_i = 1'b0, ce_i = 1'b1, instr_valid_i = 1'b0;
  logic [13:0] instr_i = '0, w;
  logic [12:0] top_of_stack_i = '0;
  logic [7:0] working_reg_i = '0;
  logic [15:0] r = 16'h0008;
  logic instr_ready_o, busy_o, rt;
  rox_pkg::rox_out_t out_o, e = '0;
  int n_fail = 0, n_checks = 0;
  always #2 clk_i = ~clk_i;
  rox_exec rox_exec_i (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .top_of_stack_i(top_of_stack_i),
    .working_reg_i(working_reg_i),
    .instr_ready_o(instr_ready_o),
    .busy_o(busy_o),
    .out_o(out_o)
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (300) begin
      @(posedge clk_i);
      r = lfsr(r);
      w = r[2] ? {4'hd, r[9:0]} : r[1:0] == 2'h3 ? r[15:2] :
        r[1:0] == 2'h0 ? 14'h0062 : {13'h0004, r[0]};
      rt = w[13:10] == 4'hd || w[13:1] == 13'h0004;
      e.program_counter_load = rt;
      e.stack_pop = rt;
      e.w_load = w[13:10] == 4'hd;
      e.global_interrupt_enable_set = w == 14'h0009;
      e.option_load = w == 14'h0062;
      if (rt) e.program_counter_value = r[12:0];
      if (e.w_load) e.w_value = w[7:0];
      if (e.option_load) e.option_value = r[15:8];
      instr_i <= w;
      top_of_stack_i <= r[12:0];
      working_reg_i <= r[15:8];
      instr_valid_i <= 1'b1;
      @(posedge clk_i);
      instr_valid_i <= rt;
      #1;
      `CHK("out", {rt, !rt, e}, {busy_o, instr_ready_o, out_o})
    end
    $display("random test done");
    print_verdict;
  end
endmodule : rox_exec_tb
`default_nettype wire
